// File: rtl/ufp_pkg.sv
// Contract
// - sync mode needs config plus command
// - sync transfers on fifo clock rise
// - device drives continuous fifo clock; held low outside sync mode
// - sync bus driven only while enable low
// - sync read moves byte when both low
// - sync write moves byte when both low
// - held read fetches byte each cycle
// - held write stores byte each cycle
// - awake strobe flushes transmit data
// - suspended strobe requests resume if enabled
// - async mode chosen by configuration
// - async transfers on strobe edges
// - async bus driven only while read low
// - avail goes high after every read
// - present on fall, fetch on rise
// - async write captures on falling strobe
// - flags undriven during reset
package ufp_pkg;
	localparam int DATA_W = 8;
	localparam int PIN_W = 12;
	// pin vector layout
	localparam int PIN_RD = 8;
	localparam int PIN_WR = 9;
	localparam int PIN_OE = 10;
	localparam int PIN_SIWU = 11;
	localparam logic [PIN_W-1:0] PIN_RST = 12'hF00;
	localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
	// configuration memory mode codes
	localparam logic [1:0] CFG_SYNC = 2'h1;
	localparam logic [1:0] CFG_ASYNC = 2'h2;
	// fifo clock timing
	localparam int REF_CLK_MHZ = 100;
	localparam int FIFO_CLK_MHZ = 60;
	localparam int FIFO_HALF_RAW = REF_CLK_MHZ / (2 * FIFO_CLK_MHZ);
	localparam int FIFO_HALF = (FIFO_HALF_RAW < 1) ? 1 : FIFO_HALF_RAW;
	localparam logic [3:0] FIFO_HALF_CNT = 4'(FIFO_HALF - 1);
	typedef enum logic [1:0] {MODE_IDLE, MODE_SYNC, MODE_ASYNC} ufp_mode_e;
endpackage

// File: rtl/ufp_fifo_port.sv
`timescale 1ns/10ps
module ufp_pin_sync
	import ufp_pkg::*;
#(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
)(
	input  wire logic         ref_clk,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] pinOut
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s1_q <= RST;
			s2_q <= RST;
			s3_q <= RST;
			pinOut <= RST;
		end
		else
		begin
			s1_q <= pinIn;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// take a change only once two stages agree
			for (int i = 0; i < W; i++)
				if (s2_q[i] == s3_q[i])
					pinOut[i] <= s3_q[i];
		end
	end
endmodule

module ufp_fifo_port
	import ufp_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              reset_n,
	input  wire logic [1:0]        cfgMode,
	input  wire logic              setModeCmd,
	input  wire logic              remoteWakeEn,
	input  wire logic              usbSuspended,
	input  wire logic              rxInValid,
	input  wire logic [DATA_W-1:0] rxInData,
	output logic                   rxInReady,
	output logic                   txOutValid,
	output logic      [DATA_W-1:0] txOutData,
	input  wire logic              txOutReady,
	output logic                   sendImmediate,
	output logic                   resumeRequest,
	output logic                   fifoClk,
	input  wire logic [DATA_W-1:0] fifoDataIn,
	output logic      [DATA_W-1:0] fifoDataOut,
	output logic                   fifoDataOe,
	output logic                   rxDataAvailN,
	output logic                   rxDataAvailOe,
	output logic                   txSpaceN,
	output logic                   txSpaceOe,
	input  wire logic              readStrobeN,
	input  wire logic              writeStrobe,
	input  wire logic              outEnableN,
	input  wire logic              sendImmediateWakeN,
	output logic                   powerEnableN
);
	// ----------------------------------------
	// pin sampling
	// ----------------------------------------
	logic [PIN_W-1:0]  pins;
	logic [DATA_W-1:0] busIn;
	logic              rdN;
	logic              wrN;
	logic              oeN;
	logic              siwuN;
	logic              rdPrev_q;
	logic              wrPrev_q;
	logic              siwuPrev_q;
	logic              rdFall;
	logic              rdRise;
	logic              wrFall;
	logic              siwuFall;

	ufp_pin_sync #(.W(PIN_W), .RST(PIN_RST)) uPins (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.pinIn   ({sendImmediateWakeN, outEnableN, writeStrobe, readStrobeN, fifoDataIn}),
		.pinOut  (pins)
	);

	assign busIn = pins[DATA_W-1:0];
	assign rdN = pins[PIN_RD];
	assign wrN = pins[PIN_WR];
	assign oeN = pins[PIN_OE];
	assign siwuN = pins[PIN_SIWU];

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rdPrev_q <= 1'b1;
			wrPrev_q <= 1'b1;
			siwuPrev_q <= 1'b1;
		end
		else
		begin
			rdPrev_q <= rdN;
			wrPrev_q <= wrN;
			siwuPrev_q <= siwuN;
		end
	end

	assign rdFall = rdPrev_q & ~rdN;
	assign rdRise = ~rdPrev_q & rdN;
	assign wrFall = wrPrev_q & ~wrN;
	assign siwuFall = siwuPrev_q & ~siwuN;

	// ----------------------------------------
	// mode selection
	// ----------------------------------------
	ufp_mode_e mode_q;
	logic      modeSync;
	logic      modeAsync;
	logic      modeActive;

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			mode_q <= MODE_IDLE;
		else
		begin
			case (cfgMode)
				CFG_ASYNC: mode_q <= MODE_ASYNC;
				CFG_SYNC:
				begin
					if (setModeCmd)
						mode_q <= MODE_SYNC;
					else if (mode_q == MODE_ASYNC)
						mode_q <= MODE_IDLE;
				end
				default: mode_q <= MODE_IDLE;
			endcase
		end
	end

	assign modeSync = (mode_q == MODE_SYNC);
	assign modeAsync = (mode_q == MODE_ASYNC);
	assign modeActive = modeSync | modeAsync;

	// ----------------------------------------
	// fifo clock generation
	// ----------------------------------------
	logic [3:0] clkCnt_q;
	logic       fifoClk_q;
	logic       fifoRise;

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			clkCnt_q <= 4'h0;
			fifoClk_q <= 1'b0;
		end
		else if (!modeSync)
		begin
			clkCnt_q <= 4'h0;
			fifoClk_q <= 1'b0;
		end
		else if (clkCnt_q == FIFO_HALF_CNT)
		begin
			clkCnt_q <= 4'h0;
			fifoClk_q <= ~fifoClk_q;
		end
		else
			clkCnt_q <= clkCnt_q + 4'h1;
	end

	assign fifoClk = fifoClk_q;
	// edge on which the next rising clock goes out
	assign fifoRise = modeSync & ~fifoClk_q & (clkCnt_q == FIFO_HALF_CNT);

	// ----------------------------------------
	// receive side
	// ----------------------------------------
	logic              rxFull_q;
	logic [DATA_W-1:0] rxHold_q;
	logic              rdTook_q;
	logic              rxPop;

	// async pop on rise only if a byte was shown at the fall
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			rdTook_q <= 1'b0;
		else if (!modeAsync || rdRise)
			rdTook_q <= 1'b0;
		else if (rdFall && rxFull_q)
			rdTook_q <= 1'b1;
	end

	assign rxPop = (fifoRise & rxFull_q & ~rdN)
		| (modeAsync & rdRise & rdTook_q);
	assign rxInReady = modeActive & ~rxFull_q;

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			rxFull_q <= 1'b0;
		else if (rxPop)
			rxFull_q <= 1'b0;
		else if (rxInValid && rxInReady)
			rxFull_q <= 1'b1;
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			rxHold_q <= BYTE_RST;
		else if (rxInValid && rxInReady)
			rxHold_q <= rxInData;
	end

	assign fifoDataOut = rxHold_q;
	assign fifoDataOe = (modeSync & ~oeN) | (modeAsync & ~rdN);

	// ----------------------------------------
	// transmit side
	// ----------------------------------------
	logic              txFull_q;
	logic [DATA_W-1:0] txHold_q;
	logic              txPush;

	assign txPush = ~txFull_q & ((fifoRise & ~wrN)
		| (modeAsync & wrFall));

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			txFull_q <= 1'b0;
		else if (txPush)
			txFull_q <= 1'b1;
		else if (txOutReady)
			txFull_q <= 1'b0;
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			txHold_q <= BYTE_RST;
		else if (txPush)
			txHold_q <= busIn;
	end

	assign txOutValid = txFull_q;
	assign txOutData = txHold_q;

	// ----------------------------------------
	// flags
	// ----------------------------------------
	assign rxDataAvailN = ~rxFull_q;
	assign txSpaceN = txFull_q;
	assign rxDataAvailOe = modeActive;
	assign txSpaceOe = modeActive;

	// ----------------------------------------
	// send immediate and wakeup
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sendImmediate <= 1'b0;
			resumeRequest <= 1'b0;
			powerEnableN <= 1'b1;
		end
		else
		begin
			sendImmediate <= siwuFall & ~usbSuspended;
			resumeRequest <= siwuFall & usbSuspended & remoteWakeEn;
			powerEnableN <= usbSuspended;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	chk_sync_rd_pop: assert property (
		fifoRise && rxFull_q && !rdN |=> !rxFull_q)
		else $error("sync read did not pop receive byte");

	chk_sync_wr_store: assert property (
		fifoRise && !txFull_q && !wrN |=> txFull_q && txHold_q == $past(busIn))
		else $error("sync write did not store byte");

	chk_async_wr_capture: assert property (
		modeAsync && wrFall && !txFull_q |=> txFull_q && txHold_q == $past(busIn))
		else $error("async write falling edge lost");

	chk_async_rxf_high: assert property (
		modeAsync && rdRise && rdTook_q |=> rxDataAvailN)
		else $error("avail flag did not rise after read");

	chk_bus_drive: assert property (
		fifoDataOe |-> (modeSync && !oeN) || (modeAsync && !rdN))
		else $error("bus driven without enable");

	chk_fifo_clk_run: assert property (
		modeSync && $rose(fifoClk) ##1 modeSync |-> !fifoClk ##1 (fifoClk || !modeSync))
		else $error("fifo clock not running");

	chk_wake_resume: assert property (
		siwuFall && usbSuspended && remoteWakeEn |=> resumeRequest && !sendImmediate)
		else $error("resume not requested");

	chk_send_flush: assert property (
		siwuFall && !usbSuspended |=> sendImmediate && !resumeRequest)
		else $error("send immediate not issued");

	chk_sync_entry: assert property (
		$rose(modeSync) |-> $past(setModeCmd) && $past(cfgMode) == CFG_SYNC)
		else $error("sync mode entered without command");

	chk_flags_idle: assert property (
		!modeActive |-> !rxDataAvailOe && !txSpaceOe && !fifoDataOe)
		else $error("flags driven while idle");

	cov_sync_read: cover property (fifoRise && rxFull_q && !rdN);
	cov_sync_write: cover property (fifoRise && !txFull_q && !wrN);
	cov_async_read: cover property (modeAsync && rdRise && rdTook_q);
	cov_resume: cover property (siwuFall && usbSuspended && remoteWakeEn);
endmodule

// File: verification/ufp_host_model.sv
`timescale 1ns/10ps
module ufp_host_model
	import ufp_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic [DATA_W-1:0] fifoDataOut,
	input  wire logic              fifoDataOe,
	output logic                   readStrobeN,
	output logic                   writeStrobe,
	output logic                   outEnableN,
	output logic      [DATA_W-1:0] busLvl
);
	logic              hostOe = 1'b0;
	logic [DATA_W-1:0] hostData = 8'h00;
	logic [DATA_W-1:0] lastLvl = 8'h00;
	initial
	begin
		readStrobeN = 1'b1;
		writeStrobe = 1'b1;
		outEnableN = 1'b1;
	end
	// released bus shows a changing pattern
	assign busLvl = fifoDataOe ? fifoDataOut : (hostOe ? hostData : ~lastLvl);
	always @(posedge ref_clk)
		lastLvl <= busLvl;
	// strobes move only at falling edge
	task hostRead(input logic sync, output logic [DATA_W-1:0] b);
		@(negedge ref_clk);
		outEnableN = ~sync;
		repeat (2) @(negedge ref_clk);
		readStrobeN = 1'b0;
		repeat (6) @(negedge ref_clk);
		b = busLvl;
		readStrobeN = 1'b1;
		outEnableN = 1'b1;
	endtask
	task hostWrite(input logic [DATA_W-1:0] d);
		@(negedge ref_clk);
		hostOe = 1'b1;
		hostData = d;
		// byte settles through the pin filter before the strobe
		repeat (6) @(negedge ref_clk);
		writeStrobe = 1'b0;
		repeat (6) @(negedge ref_clk);
		writeStrobe = 1'b1;
		hostOe = 1'b0;
	endtask
endmodule

// File: verification/ufp_fifo_port_test.sv
`timescale 1ns/10ps
module ufp_fifo_port_test
	import ufp_pkg::*;
;
	logic              ref_clk = 1'b0;
	logic              reset_n = 1'b0;
	logic [1:0]        cfgMode = 2'h0;
	logic              setModeCmd = 1'b0;
	logic              remoteWakeEn = 1'b0;
	logic              usbSuspended = 1'b0;
	logic              rxInValid = 1'b0;
	logic [DATA_W-1:0] rxInData = 8'h00;
	logic              txOutReady = 1'b0;
	logic              sendImmediateWakeN = 1'b1;
	logic              rxInReady, txOutValid, sendImmediate, resumeRequest, fifoClk;
	logic [DATA_W-1:0] txOutData, fifoDataOut, busLvl;
	logic              fifoDataOe, rxDataAvailN, rxDataAvailOe, txSpaceN, txSpaceOe;
	logic              powerEnableN, readStrobeN, writeStrobe, outEnableN;
	int                fails = 0;
	int                n_checks = 0;

	ufp_fifo_port ufp_fifo_port_i (.ref_clk, .reset_n, .cfgMode, .setModeCmd,
		.remoteWakeEn, .usbSuspended, .rxInValid, .rxInData, .rxInReady, .txOutValid,
		.txOutData, .txOutReady, .sendImmediate, .resumeRequest, .fifoClk,
		.fifoDataIn(busLvl), .fifoDataOut, .fifoDataOe, .rxDataAvailN, .rxDataAvailOe,
		.txSpaceN, .txSpaceOe, .readStrobeN, .writeStrobe, .outEnableN,
		.sendImmediateWakeN, .powerEnableN);
	ufp_host_model ufp_host_model_i (.ref_clk, .fifoDataOut, .fifoDataOe, .readStrobeN,
		.writeStrobe, .outEnableN, .busLvl);

	always #5 ref_clk = ~ref_clk;

	task complete_run();
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e)
		begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task chkBit(input string nm, input logic e, input logic g);
		n_checks++;
		if (g !== e)
		begin
			fails++;
			$display("Error %s expected %b seen %b", nm, e, g);
		end
	endtask
	function logic pick(input int s);
		case (s)
			0: return rxDataAvailN;
			1: return txOutValid;
			2: return sendImmediate;
			3: return resumeRequest;
			default: return fifoClk;
		endcase
	endfunction
	task waitBit(input int s, input logic v);
		for (int i = 0; i < 60 && pick(s) !== v; i++)
			@(negedge ref_clk);
		chkBit("wait", v, pick(s));
		if (pick(s) !== v)
			complete_run();
	endtask
	task loadRx(input logic [7:0] b);
		chkBit("rxReady", 1'b1, rxInReady);
		rxInValid = 1'b1;
		rxInData = b;
		waitBit(0, 1'b0);
		rxInValid = 1'b0;
	endtask
	task asyncRead();
		logic [7:0] b;
		cfgMode = CFG_ASYNC;
		repeat (2) @(negedge ref_clk);
		chkBit("txSpace", 1'b0, txSpaceN);
		chkBit("rxAvail", 1'b1, rxDataAvailN);
		chkBit("rxOe", 1'b1, rxDataAvailOe);
		loadRx(8'hA5);
		ufp_host_model_i.hostRead(1'b0, b);
		chk("rdByte", 8'hA5, b);
		repeat (8) @(negedge ref_clk);
		chkBit("busOe", 1'b0, fifoDataOe);
		chkBit("rxAvail", 1'b1, rxDataAvailN);
	endtask
	task asyncWrite();
		ufp_host_model_i.hostWrite(8'h3C);
		waitBit(1, 1'b1);
		chk("txData", 8'h3C, txOutData);
		chkBit("txSpace", 1'b1, txSpaceN);
		txOutReady = 1'b1;
		@(negedge ref_clk);
		txOutReady = 1'b0;
		repeat (2) @(negedge ref_clk);
		chkBit("txSpace", 1'b0, txSpaceN);
	endtask
	task wakeStrobe(input logic susp, input int s);
		usbSuspended = susp;
		remoteWakeEn = 1'b1;
		repeat (3) @(negedge ref_clk);
		chkBit("power_enable_n", susp, powerEnableN);
		sendImmediateWakeN = 1'b0;
		repeat (3) @(negedge ref_clk);
		sendImmediateWakeN = 1'b1;
		waitBit(s, 1'b1);
		usbSuspended = 1'b0;
	endtask
	task syncXfer();
		logic [7:0] b;
		cfgMode = CFG_SYNC;
		setModeCmd = 1'b1;
		@(negedge ref_clk);
		setModeCmd = 1'b0;
		waitBit(4, 1'b1);
		waitBit(4, 1'b0);
		loadRx(8'h77);
		ufp_host_model_i.hostRead(1'b1, b);
		chk("syncRd", 8'h77, b);
		ufp_host_model_i.hostWrite(8'h5A);
		waitBit(1, 1'b1);
		chk("syncWr", 8'h5A, txOutData);
	endtask

	initial
	begin
		repeat (6) @(negedge ref_clk);
		chkBit("rxOe", 1'b0, rxDataAvailOe);
		chkBit("txOe", 1'b0, txSpaceOe);
		reset_n = 1'b1;
		@(negedge ref_clk);
		asyncRead();
		asyncWrite();
		wakeStrobe(1'b0, 2);
		wakeStrobe(1'b1, 3);
		syncXfer();
		complete_run();
	end
endmodule
